// >>> hdl/ptd_decoder.sv
// ptd_decoder: serial command decoder moving wiper settings between live wipers and saved slots.
// assumes the host serial clock is well below a quarter of clk_in so every edge is sampled.
//
// Functional notes
// - global store copies all wipers to slot
// - single store copies one wiper to slot
// - single recall loads slot into one wiper
// - step frame: each later bit steps wiper
// - nonvolatile write starts only after frame ends
// - global recall loads slot into every wiper
// - bit high steps up, low steps down
// - status byte reports write in progress bit0
`timescale 1ns/100ps
`default_nettype none
module ptd_decoder
	import ptd_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = PTD_NV_WRITE_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// serial pins and address straps
	input wire ptd_pins_t pins_in,
	// serial output
	output ptd_sout_t sout_out,
	// wiper positions and write status
	output ptd_wipers_t wiper_position_reg_out,
	output logic write_in_progress_out
);

	localparam int TW = $clog2(NV_WRITE_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(NV_WRITE_CYCLES);
	localparam logic [TW-1:0] TIMER_ONE = TW'(1);

	typedef struct packed {
		ptd_state_t fsm;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] out_sh;
		logic so_oe;
		logic sck_prev;
		logic pend_store;
		logic pend_global;
		logic [1:0] pend_slot;
		logic [1:0] pend_ch;
		logic write_in_progress;
		logic [TW-1:0] timer;
		ptd_wipers_t wiper;
		ptd_slots_t slots;
	} ptd_core_t;

	localparam ptd_core_t CORE_RESET = '{
		fsm: PTD_ST_IDLE,
		bit_cnt: PTD_BIT_FIRST,
		shift: 8'h00,
		out_sh: 8'h00,
		so_oe: 1'b0,
		sck_prev: 1'b0,
		pend_store: 1'b0,
		pend_global: 1'b0,
		pend_slot: 2'h0,
		pend_ch: 2'h0,
		write_in_progress: 1'b0,
		timer: '0,
		wiper: {PTD_NUM_CH{PTD_WIPER_RESET}},
		slots: {(PTD_NUM_CH * PTD_NUM_SLOTS){PTD_WIPER_RESET}}
	};

	// saturating one-segment move
	function automatic logic [7:0] ptd_step(input logic [7:0] pos, input logic up);
		logic [7:0] res;
		res = pos;
		if (up && pos != PTD_WIPER_MAX) begin
			res = pos + 8'h01;
		end else if (!up && pos != PTD_WIPER_MIN) begin
			res = pos - 8'h01;
		end
		return res;
	endfunction

	logic [$bits(ptd_pins_t)-1:0] pins_raw;
	ptd_pins_t pins;
	ptd_core_t r;
	ptd_core_t n;
	logic sck_rise;
	logic sck_fall;
	logic byte_done;
	logic [7:0] byte_nxt;

	// pins come from the host, so resynchronise them first
	ptd_sync #(
		.WIDTH($bits(ptd_pins_t)),
		.RESET_VAL(PTD_PINS_IDLE)
	) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.d_in(pins_in),
		.q_out(pins_raw)
	);

	assign pins = ptd_pins_t'(pins_raw);

	// edge detection on the synchronised serial clock
	assign sck_rise = pins.sck & ~r.sck_prev;
	assign sck_fall = ~pins.sck & r.sck_prev;
	assign byte_nxt = {r.shift[6:0], pins.si};
	assign byte_done = sck_rise && (r.bit_cnt == PTD_BIT_LAST);

	// next-state logic for the whole block
	always_comb begin
		n = r;
		n.sck_prev = pins.sck;
		// write timer runs independently of the serial frame
		if (r.write_in_progress) begin
			if (r.timer <= TIMER_ONE) begin
				n.write_in_progress = 1'b0;
				n.timer = '0;
			end else begin
				n.timer = r.timer - TIMER_ONE;
			end
		end
		if (pins.cs_n) begin
			// frame closed: a pending store commits now and starts the write
			if (r.pend_store) begin
				for (int ch = 0; ch < PTD_NUM_CH; ch++) begin
					if (r.pend_global || r.pend_ch == 2'(ch)) begin
						n.slots[ch][r.pend_slot] = r.wiper[ch];
					end
				end
				n.write_in_progress = 1'b1;
				n.timer = TIMER_LOAD;
			end
			n.pend_store = 1'b0;
			n.fsm = PTD_ST_IDLE;
			n.bit_cnt = PTD_BIT_FIRST;
			n.so_oe = 1'b0;
		end else begin
			unique case (r.fsm)
				PTD_ST_IDLE: begin
					n.fsm = PTD_ST_ADDR;
					n.bit_cnt = PTD_BIT_FIRST;
				end
				PTD_ST_ADDR: begin
					if (sck_rise) begin
						n.shift = byte_nxt;
						n.bit_cnt = r.bit_cnt + 3'h1;
					end
					if (byte_done) begin
						// prefix and both address select bits must match
						if (byte_nxt == {PTD_ADDR_PREFIX, pins.addr_select_hi, pins.addr_select_lo}) begin
							n.fsm = PTD_ST_INSTR;
						end else begin
							n.fsm = PTD_ST_SKIP;
						end
					end
				end
				PTD_ST_INSTR: begin
					if (sck_rise) begin
						n.shift = byte_nxt;
						n.bit_cnt = r.bit_cnt + 3'h1;
					end
					if (byte_done) begin
						n.fsm = PTD_ST_SKIP;
						n.pend_slot = byte_nxt[3:2];
						n.pend_ch = byte_nxt[1:0];
						if (byte_nxt == PTD_STATUS_CMD) begin
							n.fsm = PTD_ST_STAT;
							n.so_oe = 1'b1;
							n.out_sh = {PTD_STATUS_PAD, r.write_in_progress};
						end else if (byte_nxt[7:4] == PTD_OP_GSTORE && byte_nxt[1:0] == PTD_FIELD_ZERO) begin
							n.pend_store = ~r.write_in_progress;
							n.pend_global = 1'b1;
						end else if (byte_nxt[7:4] == PTD_OP_STORE) begin
							n.pend_store = ~r.write_in_progress;
							n.pend_global = 1'b0;
						end else if (byte_nxt[7:4] == PTD_OP_RECALL) begin
							n.wiper[byte_nxt[1:0]] = r.slots[byte_nxt[1:0]][byte_nxt[3:2]];
						end else if (byte_nxt[7:4] == PTD_OP_GRECALL && byte_nxt[1:0] == PTD_FIELD_ZERO) begin
							for (int ch = 0; ch < PTD_NUM_CH; ch++) begin
								n.wiper[ch] = r.slots[ch][byte_nxt[3:2]];
							end
						end else if (byte_nxt[7:4] == PTD_OP_STEP && byte_nxt[3:2] == PTD_FIELD_ZERO) begin
							n.fsm = PTD_ST_STEP;
						end
					end
				end
				PTD_ST_STEP: begin
					// every sampled bit until the frame ends moves the wiper one step, except a step down at PTD_WIPER_MIN or a step up at PTD_WIPER_MAX, which holds
					if (sck_rise) begin
						n.wiper[r.pend_ch] = ptd_step(r.wiper[r.pend_ch], pins.si);
					end
				end
				PTD_ST_STAT: begin
					// count read clocks; the instruction's own last fall must not shift, or bit 7 is lost
					if (sck_rise) begin
						n.bit_cnt = r.bit_cnt + 3'h1;
					end
					// status byte leaves msb first, shifted on the falls after each read clock
					if (sck_fall && r.bit_cnt != PTD_BIT_FIRST) begin
						n.out_sh = {r.out_sh[6:0], 1'b0};
					end
				end
				PTD_ST_SKIP: begin
					n.fsm = PTD_ST_SKIP;
				end
				default: begin
					n.fsm = PTD_ST_IDLE;
				end
			endcase
		end
	end

	// single state register, frozen while the enable is low
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r <= CORE_RESET;
		end else if (ce_in) begin
			r <= n;
		end
	end

	// outputs straight from state
	assign sout_out = '{so: r.out_sh[7], so_oe: r.so_oe};
	assign wiper_position_reg_out = r.wiper;
	assign write_in_progress_out = r.write_in_progress;

endmodule
`default_nettype wire

// >>> hdl/ptd_pkg.sv
// ptd_pkg: shared constants and types for the potentiometer transfer command decoder.
// assumes a single 10 MHz system clock; serial pins arrive asynchronously.
package ptd_pkg;

	// clock and timing
	localparam int PTD_CLK_PERIOD_NS = 100;
	localparam int PTD_NV_WRITE_TIME_US = 5000;
	localparam int PTD_NV_WRITE_CYCLES = (PTD_NV_WRITE_TIME_US * 1000 + PTD_CLK_PERIOD_NS - 1) / PTD_CLK_PERIOD_NS;

	// geometry
	localparam int PTD_NUM_CH = 4;
	localparam int PTD_NUM_SLOTS = 4;
	localparam int PTD_WIPER_W = 8;

	// serial frame layout
	localparam logic [2:0] PTD_BIT_FIRST = 3'h0;
	localparam logic [2:0] PTD_BIT_LAST = 3'h7;
	localparam logic [5:0] PTD_ADDR_PREFIX = 6'h14;
	localparam logic [3:0] PTD_OP_GSTORE = 4'h8;
	localparam logic [3:0] PTD_OP_STORE = 4'hE;
	localparam logic [3:0] PTD_OP_RECALL = 4'hD;
	localparam logic [3:0] PTD_OP_GRECALL = 4'h1;
	localparam logic [3:0] PTD_OP_STEP = 4'h2;
	localparam logic [7:0] PTD_STATUS_CMD = 8'h51;
	localparam logic [1:0] PTD_FIELD_ZERO = 2'h0;
	localparam logic [6:0] PTD_STATUS_PAD = 7'h00;

	// reset and limit values
	localparam logic [7:0] PTD_WIPER_RESET = 8'h00;
	localparam logic [7:0] PTD_WIPER_MIN = 8'h00;
	localparam logic [7:0] PTD_WIPER_MAX = 8'hFF;

	// serial pins as seen by the device
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic addr_select_hi;
		logic addr_select_lo;
	} ptd_pins_t;

	localparam ptd_pins_t PTD_PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, addr_select_hi: 1'b0, addr_select_lo: 1'b0};

	// serial output pin pair
	typedef struct packed {
		logic so;
		logic so_oe;
	} ptd_sout_t;

	typedef logic [PTD_NUM_CH-1:0][PTD_WIPER_W-1:0] ptd_wipers_t;
	typedef logic [PTD_NUM_CH-1:0][PTD_NUM_SLOTS-1:0][PTD_WIPER_W-1:0] ptd_slots_t;

	// frame states, one-hot
	typedef enum logic [5:0] {
		PTD_ST_IDLE = 6'h01,
		PTD_ST_ADDR = 6'h02,
		PTD_ST_INSTR = 6'h04,
		PTD_ST_STEP = 6'h08,
		PTD_ST_STAT = 6'h10,
		PTD_ST_SKIP = 6'h20
	} ptd_state_t;

endpackage

// >>> hdl/ptd_sync.sv
// ptd_sync: two-flop synchroniser for a bundle of asynchronous pins.
// assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/100ps
`default_nettype none
module ptd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// pins and synchronised copy
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= RESET_VAL;
			q_r <= RESET_VAL;
		end else if (ce_in) begin
			meta_r <= d_in;
			q_r <= meta_r;
		end
	end

	assign q_out = q_r;

endmodule
`default_nettype wire

// >>> testbench/ptd_decoder_chk.sv
// ptd_decoder_chk: port timing checks for the decoder.
// assumes it is bound to ptd_decoder and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module ptd_decoder_chk
	import ptd_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = PTD_NV_WRITE_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	// pins and outputs
	input wire ptd_pins_t pins_in,
	input wire ptd_sout_t sout_out,
	input wire ptd_wipers_t wiper_position_reg_out,
	input wire logic write_in_progress_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	int busy_r;
	// length of the running write pulse
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_r <= 0;
		end else if (ce_in) begin
			busy_r <= write_in_progress_out ? busy_r + 1 : 0;
		end
	end
	sequence s_frame_closed;
		pins_in.cs_n && $past(pins_in.cs_n, 2) && !$past(pins_in.cs_n, 6);
	endsequence
	a_wip_hold: assert property ($rose(write_in_progress_out) |-> write_in_progress_out[*8])
		else $error("write pulse too short");
	a_wip_bound: assert property (busy_r <= NV_WRITE_CYCLES + 1)
		else $error("write pulse too long");
	a_wip_full: assert property ($fell(write_in_progress_out) |-> busy_r >= NV_WRITE_CYCLES - 1)
		else $error("write pulse ended early");
	a_wip_after_end: assert property ($rose(write_in_progress_out) |-> s_frame_closed)
		else $error("write began inside open frame");
	a_idle_still: assert property (pins_in.cs_n[*4] |=> $stable(wiper_position_reg_out))
		else $error("wiper moved outside frame");
	a_oe_in_frame: assert property (sout_out.so_oe |-> !$past(pins_in.cs_n, 3))
		else $error("serial out driven outside frame");
	a_status_msb: assert property ($rose(sout_out.so_oe) |-> !sout_out.so)
		else $error("status top bit not zero");
	a_ce_freeze: assert property (!ce_in |=> $stable(wiper_position_reg_out) && $stable(write_in_progress_out))
		else $error("state moved while disabled");
endmodule
bind ptd_decoder ptd_decoder_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .ce_in(ce_in), .pins_in(pins_in), .sout_out(sout_out),
	.wiper_position_reg_out(wiper_position_reg_out), .write_in_progress_out(write_in_progress_out));
`default_nettype wire

// >>> testbench/ptd_decoder_tb.sv
// ptd_decoder_tb: self-checking bench for the decoder.
// assumes straps hi=1 lo=0 and a short write time.
`timescale 1ns/100ps
`default_nettype none
module ptd_decoder_tb
	import ptd_pkg::*;
;
	localparam int NV = 600;
	localparam logic [7:0] ADR = {PTD_ADDR_PREFIX, 2'h2};
	logic clk_in, reset_n_in, ce_in, cs_n, sck, si;
	logic [7:0] rx;
	ptd_pins_t pins;
	ptd_sout_t sout;
	ptd_wipers_t wipers;
	logic write_in_progress;
	int err_count = 0, checks = 0, cyc = 0;
	assign pins = '{cs_n: cs_n, sck: sck, si: si, addr_select_hi: 1'b1, addr_select_lo: 1'b0};
	ptd_decoder #(.NV_WRITE_CYCLES(NV)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
		.pins_in(pins), .sout_out(sout), .wiper_position_reg_out(wipers), .write_in_progress_out(write_in_progress));
	// serial out floats to its pull-up while the device does not drive it
	ptd_host HOST (.clk_in(clk_in), .so_in(sout.so_oe ? sout.so : 1'b1), .cs_n_out(cs_n), .sck_out(sck),
		.si_out(si), .rx_out(rx));
	// clock and hang guard
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic go(input logic [7:0] ins, input int n, input logic d);
		HOST.frame(ADR, ins, n, d, 6);
	endtask
	// steps up, down and below zero
	task automatic t_step();
		go(8'h21, 3, 1'b1);
		go(8'h21, 1, 1'b0);
		go(8'h22, 2, 1'b0);
		go(8'h23, 4, 1'b1);
		check("wipers", 32'h04000200, wipers);
	endtask
	// single store, refused store while busy, busy status, single recall
	task automatic t_store();
		go(8'hE9, 0, 1'b0);
		go(8'hE5, 0, 1'b0);
		go(8'h51, 8, 1'b0);
		check("status", 32'h01, rx);
		repeat (NV) @(negedge clk_in);
		go(8'h51, 8, 1'b0);
		check("status", 32'h00, rx);
		go(8'h21, 2, 1'b1);
		go(8'hD5, 0, 1'b0);
		check("wipers", 32'h04000000, wipers);
		go(8'hD9, 0, 1'b0);
		check("wipers", 32'h04000200, wipers);
	endtask
	// global store and global recall
	task automatic t_global();
		go(8'h84, 0, 1'b0);
		repeat (NV) @(negedge clk_in);
		go(8'h20, 3, 1'b1);
		go(8'h23, 1, 1'b0);
		check("wipers", 32'h03000203, wipers);
		go(8'h14, 0, 1'b0);
		check("wipers", 32'h04000200, wipers);
	endtask
	// foreign address, slow host, then enable frozen during a write
	task automatic t_other();
		HOST.frame({PTD_ADDR_PREFIX, 2'h1}, 8'h21, 2, 1'b1, 10);
		check("wipers", 32'h04000200, wipers);
		go(8'hE1, 0, 1'b0);
		ce_in = 1'b0;
		repeat (NV) @(negedge clk_in);
		check("busy", 32'h1, write_in_progress);
		ce_in = 1'b1;
		repeat (NV) @(negedge clk_in);
		check("busy", 32'h0, write_in_progress);
		go(8'h21, 1, 1'b1);
		check("wipers", 32'h04000300, wipers);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// reset, then scenarios in turn
	initial begin
		reset_n_in = 1'b0;
		ce_in = 1'b1;
		repeat (12) @(negedge clk_in);
		reset_n_in = 1'b1;
		check("wipers", 32'h0, wipers);
		t_step();
		t_store();
		t_global();
		t_other();
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> testbench/ptd_host.sv
// ptd_host: serial bus master model sending frames to the decoder.
// assumes clk_in is the decoder clock; pins move at its falling edge.
`timescale 1ns/100ps
`default_nettype none
module ptd_host (
	// clock and serial out of the device
	input wire logic clk_in,
	input wire logic so_in,
	// serial pins towards the device
	output logic cs_n_out,
	output logic sck_out,
	output logic si_out,
	// last eight bits read back
	output logic [7:0] rx_out
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
		rx_out = 8'h00;
	end
	// one bit, msb first; so captured as sck rises
	task automatic tick(input logic b, input int hp);
		si_out = b;
		repeat (hp) @(negedge clk_in);
		sck_out = 1'b1;
		rx_out = {rx_out[6:0], so_in};
		repeat (hp) @(negedge clk_in);
		sck_out = 1'b0;
	endtask
	// address byte, instruction byte, then n bits of d
	task automatic frame(input logic [7:0] adr, input logic [7:0] ins, input int n, input logic d, input int hp);
		logic [15:0] w;
		w = {adr, ins};
		@(negedge clk_in);
		cs_n_out = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			tick(w[i], hp);
		end
		for (int i = 0; i < n; i++) begin
			tick(d, hp);
		end
		repeat (4) @(negedge clk_in);
		cs_n_out = 1'b1;
		si_out = ~si_out; // released line shows no stale bit
		repeat (6) @(negedge clk_in);
	endtask
endmodule
`default_nettype wire
